// ---- core/dcs_pkg.sv ----
// Package for the converter input clock divider and latch path.
// Assumes one system clock; the double-rate converter clock arrives on a pin.
package dcs_pkg;

    localparam int DATA_W = 14;
    localparam logic [13:0] CODE_MAX = 14'h3fff;
    localparam logic [14:0] CODE_SPAN = 15'h4000;
    localparam logic [13:0] CODE_RST = 14'h0000;
    // Half-rate clock level forced while reset is held
    localparam logic HALF_CLK_RST = 1'b1;
    // Lock pin copy trails the half-rate clock by this many system cycles
    localparam int LOCK_DELAY = 1;
    localparam int BUF_DEPTH = 2;

    typedef struct packed {
        logic [13:0] code;
    } dcs_word_s;

    typedef struct packed {
        logic [14:0] true_units;
        logic [13:0] comp_units;
    } dcs_split_s;

    typedef enum logic [1:0] {
        DCS_HOLD,
        DCS_LOW,
        DCS_RUN
    } dcs_phase_e;

endpackage

// ---- core/dcs_buf2.sv ----
// Two-entry valid/ready buffer for input words.
// Assumes both sides on clk_sys with synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module dcs_buf2
    import dcs_pkg::*;
#(
    parameter int DEPTH = BUF_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire dcs_word_s in_word,
    output logic out_valid,
    input wire logic out_ready,
    output dcs_word_s out_word
);
    dcs_word_s mem_q [DEPTH];
    logic [1:0] cnt_q;
    logic rd_q;
    logic wr_q;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign in_ready = (cnt_q != 2'(DEPTH));
    assign out_valid = (cnt_q != 2'h0);
    assign out_word = mem_q[rd_q];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_q] <= in_word;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_q <= 2'h0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
        end else begin
            if (push) begin
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_q + 2'(push) - 2'(pop);
        end
    end
endmodule
`default_nettype wire

// ---- core/dcs_input_sync.sv ----
// Converter input timing: divides the double-rate clock, drives the lock pin
// copy, latches words and splits full-scale current by code.
// Assumes the double-rate clock and reset pin are slower than clk_sys / 4.
//
// Summary of operation
// - Device divides converter clock by two for the half-rate latch clock.
// - Delayed copy of half-rate clock drives the lock status pin.
// - Latch updates only on double-rate edge matching half-rate rising edge.
// - While reset is high, half-rate clock and lock pin copy stay high.
// - First double-rate rising edge after reset drives half-rate clock low.
// - Second edge drives it high and loads both input latch stages.
// - All-ones code gives near full current true, none on complement.
// - True output is code/16384, complement is 16383 minus code.
// - Input word is straight binary, data_msb most significant.
`timescale 1ns/1ps
`default_nettype none
module dcs_input_sync
    import dcs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic conv_clk_pin,
    input wire logic reset_pin,
    input wire logic data_valid,
    output logic data_ready,
    input wire logic [13:0] data_in,
    output logic half_clk,
    output logic lock_status_clock_out,
    output logic lock_status_oe_n,
    output logic [13:0] latched_code,
    output logic latch_strobe,
    output logic [14:0] output_current_true,
    output logic [13:0] output_current_complement
);
    logic clk_s1_q;
    logic clk_s2_q;
    logic clk_s3_q;
    logic rst_s1_q;
    logic rst_s2_q;
    logic rise;
    dcs_phase_e phase_q;
    logic half_q;
    logic [LOCK_DELAY-1:0] lock_dly_q;
    dcs_word_s first_stage_q;
    dcs_word_s buf_word;
    logic buf_valid;
    logic buf_ready;
    dcs_word_s in_word;
    logic load;
    dcs_split_s split_rst;
    dcs_split_s split_new;

    function automatic dcs_split_s split_code(input logic [13:0] code);
        dcs_split_s s;
        s.true_units = {1'b0, code};
        s.comp_units = CODE_MAX - code;
        return s;
    endfunction

    // Two stages before any logic sees the pins
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            clk_s1_q <= 1'b0;
            clk_s2_q <= 1'b0;
            clk_s3_q <= 1'b0;
            rst_s1_q <= 1'b1;
            rst_s2_q <= 1'b1;
        end else begin
            clk_s1_q <= conv_clk_pin;
            clk_s2_q <= clk_s1_q;
            clk_s3_q <= clk_s2_q;
            rst_s1_q <= reset_pin;
            rst_s2_q <= rst_s1_q;
        end
    end

    assign rise = clk_s2_q && !clk_s3_q;

    // Divide by two; reset pin parks the phase high
    always_ff @(posedge clk_sys) begin
        if (rst || rst_s2_q) begin
            phase_q <= DCS_HOLD;
            half_q <= HALF_CLK_RST;
        end else if (rise) begin
            case (phase_q)
                DCS_HOLD: begin
                    phase_q <= DCS_LOW;
                    half_q <= 1'b0;
                end
                DCS_LOW, DCS_RUN: begin
                    phase_q <= DCS_RUN;
                    half_q <= ~half_q;
                end
                default: begin
                    phase_q <= DCS_HOLD;
                    half_q <= HALF_CLK_RST;
                end
            endcase
        end
    end

    // Latch only on the edge raising the half-rate clock
    assign load = rise && !rst_s2_q && !half_q && (phase_q != DCS_HOLD);

    // Lock pin copy trails by a register stage
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lock_dly_q <= {LOCK_DELAY{HALF_CLK_RST}};
        end else begin
            // Oldest stage drops off the top, so any delay depth works
            lock_dly_q <= LOCK_DELAY'({lock_dly_q, half_q});
        end
    end

    always_ff @(posedge clk_sys) begin
        half_clk <= half_q;
        lock_status_clock_out <= lock_dly_q[LOCK_DELAY-1];
        lock_status_oe_n <= 1'b0;
    end

    // Straight binary, bit 13 is data_msb
    assign in_word.code = data_in;

    dcs_buf2 u_buf (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(data_valid),
        .in_ready(buf_ready),
        .in_word(in_word),
        .out_valid(buf_valid),
        .out_ready(load),
        .out_word(buf_word)
    );

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            data_ready <= 1'b0;
        end else begin
            data_ready <= buf_ready;
        end
    end

    // Master then slave stage both load on the update edge; an empty buffer
    // holds the previous code rather than inventing one
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            first_stage_q.code <= CODE_RST;
            latched_code <= CODE_RST;
            latch_strobe <= 1'b0;
        end else begin
            latch_strobe <= load;
            if (load && buf_valid) begin
                first_stage_q <= buf_word;
                latched_code <= buf_word.code;
            end
        end
    end

    // Current split in units of full scale / 16384
    assign split_rst = split_code(CODE_RST);
    assign split_new = split_code(buf_word.code);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            output_current_true <= split_rst.true_units;
            output_current_complement <= split_rst.comp_units;
        end else if (load && buf_valid) begin
            output_current_true <= split_new.true_units;
            output_current_complement <= split_new.comp_units;
        end
    end

    // Pin reset after the synchroniser, and the two steps of the reset walk
    sequence s_pin_held;
        rst_s2_q;
    endsequence

    sequence s_first_rise;
        phase_q == DCS_HOLD && rise && !rst_s2_q;
    endsequence

    sequence s_second_rise;
        phase_q == DCS_LOW && rise && !rst_s2_q;
    endsequence

    property p_reset_high;
        @(posedge clk_sys) disable iff (rst)
            s_pin_held |=> half_q;
    endproperty
    a_reset_high: assert property (p_reset_high)
        else $error("half clock not high in reset");

    property p_reset_phase;
        @(posedge clk_sys) disable iff (rst)
            s_pin_held |=> (phase_q == DCS_HOLD);
    endproperty
    a_reset_phase: assert property (p_reset_phase)
        else $error("divider not parked in reset");

    // Lock pin sits three register stages behind the pin reset
    property p_reset_lock;
        @(posedge clk_sys) disable iff (rst)
            s_pin_held |=> ##2 lock_status_clock_out;
    endproperty
    a_reset_lock: assert property (p_reset_lock)
        else $error("lock pin not high in reset");

    property p_first_low;
        @(posedge clk_sys) disable iff (rst)
            s_first_rise |=> !half_q;
    endproperty
    a_first_low: assert property (p_first_low)
        else $error("first edge did not drop half clock");

    property p_second_load;
        @(posedge clk_sys) disable iff (rst)
            s_second_rise |-> load;
    endproperty
    a_second_load: assert property (p_second_load)
        else $error("second edge did not load");

    property p_second_high;
        @(posedge clk_sys) disable iff (rst)
            s_second_rise |=> (half_q && phase_q == DCS_RUN);
    endproperty
    a_second_high: assert property (p_second_high)
        else $error("second edge did not raise half clock");

    property p_toggle;
        @(posedge clk_sys) disable iff (rst)
            (phase_q != DCS_HOLD && rise && !rst_s2_q) |=> (half_q != $past(half_q));
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("half clock did not toggle");

    property p_steady;
        @(posedge clk_sys) disable iff (rst)
            (!rise && !rst_s2_q) |=> $stable(half_q);
    endproperty
    a_steady: assert property (p_steady)
        else $error("half clock moved without edge");

    property p_half_out;
        @(posedge clk_sys) disable iff (rst)
            1'b1 |=> (half_clk == $past(half_q));
    endproperty
    a_half_out: assert property (p_half_out)
        else $error("half clock output not a registered copy");

    property p_lock_copy;
        @(posedge clk_sys) disable iff (rst)
            1'b1 |=> ##1 (lock_status_clock_out == $past(half_q, 2));
    endproperty
    a_lock_copy: assert property (p_lock_copy)
        else $error("lock pin not delayed copy");

    property p_oe_low;
        @(posedge clk_sys) disable iff (rst)
            1'b1 |=> !lock_status_oe_n;
    endproperty
    a_oe_low: assert property (p_oe_low)
        else $error("lock pin not driven");

    property p_load_rising;
        @(posedge clk_sys) disable iff (rst)
            load |=> half_q;
    endproperty
    a_load_rising: assert property (p_load_rising)
        else $error("latch off the rising phase");

    property p_strobe;
        @(posedge clk_sys) disable iff (rst)
            1'b1 |=> (latch_strobe == $past(load));
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("strobe does not follow the latch edge");

    property p_load_word;
        @(posedge clk_sys) disable iff (rst)
            (load && buf_valid) |=> (latched_code == $past(buf_word.code));
    endproperty
    a_load_word: assert property (p_load_word)
        else $error("latched code is not the buffered word");

    property p_code_hold;
        @(posedge clk_sys) disable iff (rst)
            !load |=> $stable(latched_code);
    endproperty
    a_code_hold: assert property (p_code_hold)
        else $error("code moved between updates");

    // An empty buffer at the latch edge must not disturb the true current output
    property p_empty_hold;
        @(posedge clk_sys) disable iff (rst)
            (load && !buf_valid) |=> $stable(output_current_true);
    endproperty
    a_empty_hold: assert property (p_empty_hold)
        else $error("current moved on an empty latch edge");

    property p_split_sum;
        @(posedge clk_sys) disable iff (rst)
            ({1'b0, output_current_complement} + output_current_true) == 15'(CODE_MAX);
    endproperty
    a_split_sum: assert property (p_split_sum)
        else $error("current split does not sum");

    property p_span;
        @(posedge clk_sys) disable iff (rst)
            output_current_true < CODE_SPAN;
    endproperty
    a_span: assert property (p_span)
        else $error("true current reached full scale");

    property p_full_code;
        @(posedge clk_sys) disable iff (rst)
            (latched_code == CODE_MAX) |-> (output_current_complement == 14'h0000);
    endproperty
    a_full_code: assert property (p_full_code)
        else $error("complement not zero at full code");

endmodule
`default_nettype wire

// ---- bench/dcs_src_model.sv ----
// Data source model: converter clock, reset pin and parallel words.
// Assumes clk_sys at 100 MHz; converter clock runs at clk_sys / 8.
`timescale 1ns/1ps
`default_nettype none
module dcs_src_model
    import dcs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic run,
    input wire logic push,
    input wire logic [13:0] word,
    output logic conv_clk_pin,
    output logic reset_pin,
    output logic data_valid,
    output logic [13:0] data_in
);
    logic [2:0] div_q = 3'h0;
    initial begin
        reset_pin = 1'b1;
        data_valid = 1'b0;
        data_in = 14'h0000;
    end
    // Clock stands low until reset pin is down
    assign conv_clk_pin = div_q[2];
    always @(posedge clk_sys) begin
        reset_pin <= !run;
        div_q <= (run && !reset_pin) ? div_q + 3'h1 : 3'h0;
        data_valid <= push;
        // Idle bus shows garbage, not the last word
        data_in <= push ? word : ~data_in;
    end
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the converter input timing block.
// Assumes the source model sits on the data and clock pins.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dcs_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic run = 1'b0;
    logic push = 1'b0;
    logic [13:0] word = 14'h0000;
    logic conv_clk_pin, reset_pin, data_valid, data_ready, half_clk;
    logic lock_out, lock_oe_n, latch_strobe, half_prev;
    logic [13:0] data_in, latched_code, comp, exp_code, w;
    logic [14:0] true_i;
    logic [15:0] lfsr_q = 16'h000a;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    int since = 0;
    int last_gap = 0;
    always #5 clk_sys = ~clk_sys;
    dcs_src_model src (.clk_sys(clk_sys), .run(run), .push(push), .word(word),
        .conv_clk_pin(conv_clk_pin), .reset_pin(reset_pin), .data_valid(data_valid),
        .data_in(data_in));
    dcs_input_sync dut (.clk_sys(clk_sys), .rst(rst), .conv_clk_pin(conv_clk_pin),
        .reset_pin(reset_pin), .data_valid(data_valid), .data_ready(data_ready),
        .data_in(data_in), .half_clk(half_clk), .lock_status_clock_out(lock_out),
        .lock_status_oe_n(lock_oe_n), .latched_code(latched_code),
        .latch_strobe(latch_strobe), .output_current_true(true_i),
        .output_current_complement(comp));
    function automatic logic [15:0] lfsr_next(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [14:0] exp_true(logic [13:0] c);
        return {1'b0, c};
    endfunction
    function automatic logic [13:0] exp_comp(logic [13:0] c);
        return CODE_MAX - c;
    endfunction
    task automatic chk(string what, logic [14:0] exp, logic [14:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check_out(logic [13:0] c);
        @(posedge clk_sys);
        #1;
        chk("latched_code", {1'b0, c}, {1'b0, latched_code});
        chk("current_true", exp_true(c), true_i);
        chk("current_comp", {1'b0, exp_comp(c)}, {1'b0, comp});
    endtask
    task automatic push_word(logic [13:0] v);
        chk("data_ready", 15'h0001, {14'h0000, data_ready});
        word = v;
        push = 1'b1;
        @(posedge clk_sys);
        #1;
        push = 1'b0;
    endtask
    task automatic wait_strobe();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (latch_strobe !== 1'b1 && n < 200);
        chk("strobe", 15'h0001, {14'h0000, latch_strobe});
    endtask
    task automatic start_run(logic [13:0] v);
        int n;
        push_word(v);
        exp_code = v;
        run = 1'b1;
        n = 0;
        while (half_clk !== 1'b0 && n < 60) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk("half_low", 15'h0000, {14'h0000, half_clk});
        wait_strobe();
        check_out(exp_code);
    endtask
    // Lock pin trails half clock by one cycle; also the hang limit
    always @(negedge clk_sys) begin
        cycles++;
        if (cycles > 4000) begin
            n_mismatch++;
            results();
        end
        if (!rst) begin
            chk("lock_copy", {14'h0000, half_prev}, {14'h0000, lock_out});
            chk("lock_oe_n", 15'h0000, {14'h0000, lock_oe_n});
        end
        half_prev = half_clk;
        if (latch_strobe === 1'b1) begin
            last_gap = since;
            since = 1;
        end else begin
            since++;
        end
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        chk("half_rst", 15'h0001, {14'h0000, half_clk});
        chk("lock_rst", 15'h0001, {14'h0000, lock_out});
        check_out(CODE_RST);
        $display("test reset done");
        start_run(CODE_MAX);
        for (int i = 0; i < 24; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            w = (i == 3) ? 14'h0000 : lfsr_q[13:0];
            // Every fifth slot has no word: old code must hold
            if (i % 5 != 4) begin
                push_word(w);
                exp_code = w;
            end
            wait_strobe();
            // Gap counter moves on the falling edge; read it after that
            @(negedge clk_sys);
            #1;
            chk("gap", 15'h0010, last_gap[14:0]);
            check_out(exp_code);
        end
        $display("test stream done");
        run = 1'b0;
        repeat (10) @(posedge clk_sys);
        #1;
        chk("half_hold", 15'h0001, {14'h0000, half_clk});
        chk("lock_hold", 15'h0001, {14'h0000, lock_out});
        check_out(exp_code);
        start_run(14'h2aaa);
        $display("test resync done");
        results();
    end
endmodule
`default_nettype wire
